//--- src/ect_cycle_timer.v
`timescale 1ns/1ns
`include "ect_defs.vh"

// down counter: done pulses load_val-1 cycles after the load edge, so a state that
// is left on done lasts exactly load_val cycles, never one more than the limit
module ect_cycle_timer
(
    // clock and reset
    input  wire                    core_clk,
    input  wire                    sys_rst,
    // control
    input  wire                    load,
    input  wire [`ECT_TMR_W-1:0]   load_val,
    // status
    output reg                     running,
    output reg                     done
);

    reg [`ECT_TMR_W-1:0] count_reg;   // remaining cycles

    // a load always restarts; a length of zero or one finishes at once
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            count_reg <= `ECT_RST_TMR;
            running   <= 1'b0;
            done      <= 1'b0;
        end
        else if (load)
        begin
            if (load_val <= {{(`ECT_TMR_W-1){1'b0}}, 1'b1})
            begin
                // shortest cycle: done on the very next edge
                count_reg <= `ECT_RST_TMR;
                running   <= 1'b0;
                done      <= 1'b1;
            end
            else
            begin
                // the user's state register adds the last cycle
                count_reg <= load_val - {{(`ECT_TMR_W-1){1'b0}}, 1'b1};
                running   <= 1'b1;
                done      <= 1'b0;
            end
        end
        else if (running)
        begin
            // last cycle of the busy period
            if (count_reg == {{(`ECT_TMR_W-1){1'b0}}, 1'b1})
            begin
                running <= 1'b0;
                done    <= 1'b1;
            end
            else
            begin
                done <= 1'b0;
            end
            count_reg <= count_reg - {{(`ECT_TMR_W-1){1'b0}}, 1'b1};
        end
        else
        begin
            done <= 1'b0;
        end
    end

endmodule // ect_cycle_timer

//--- src/ect_defs.vh
`ifndef ECT_DEFS_VH
`define ECT_DEFS_VH

// core clock rate in MHz
`define ECT_CLK_MHZ            100

// self-timed cycle limits, in their own units
`define ECT_WRITE_TIME_MS      6
`define ECT_BLOCK_ERASE_MS     10
`define ECT_FULL_ERASE_MS      100
`define ECT_WAKE_DELAY_US      100
`define ECT_SLEEP_DELAY_US     100

// times convert without rounding: exact integer products here
`define ECT_MS_TO_CYC(t)       ((t) * 1000 * `ECT_CLK_MHZ)
`define ECT_US_TO_CYC(t)       ((t) * `ECT_CLK_MHZ)

// width of the cycle timer (holds 10,000,000)
`define ECT_TMR_W              24

// kind of action armed by the decoder for the next select rise
`define ECT_KIND_W             3
`define ECT_KIND_NONE          3'h0
`define ECT_KIND_WRITE         3'h1
`define ECT_KIND_PAGE_ERASE    3'h2
`define ECT_KIND_BLOCK_ERASE   3'h3
`define ECT_KIND_FULL_ERASE    3'h4
`define ECT_KIND_SLEEP         3'h5
`define ECT_KIND_WAKE          3'h6

// power/cycle state codes
`define ECT_ST_W               3
`define ECT_ST_IDLE            3'h0
`define ECT_ST_PROG            3'h1
`define ECT_ST_SLEEP           3'h2
`define ECT_ST_DEEP            3'h3
`define ECT_ST_WAKE            3'h4

// serial byte width and bit counter width
`define ECT_BYTE_W             8
`define ECT_BIT_W              3

// synchronised pin indices
`define ECT_PIN_N              4
`define ECT_PIN_SEL            0
`define ECT_PIN_SCLK           1
`define ECT_PIN_SDI            2
`define ECT_PIN_PAUSE          3

// reset values
`define ECT_RST_TMR            24'h00_0000
`define ECT_RST_BYTE           8'h00

`endif

//--- src/ect_top.v
// Summary of operation
// - selected and accepting only while select low
// - select high deselects, enters standby
// - launched programming cycle always runs to completion
// - standby deferred until running cycle finishes
// - serial output released whenever deselected
// - write cycle starts on select rising edge
// - no sequence accepted before first select low
// - output bits change after serial clock falls
// - write or page erase within 6 ms
// - full erase within 100 ms
// - block erase within 10 ms
// - wake reaches standby within 100 us
// - sleep entered within 100 us
// - serial input sampled on clock rise
// - bytes travel most significant bit first
// - pause floats output, release drives again
`timescale 1ns/1ns
`include "ect_defs.vh"

module ect_top
#(
    parameter [`ECT_TMR_W-1:0] WRITE_CYC = `ECT_MS_TO_CYC(`ECT_WRITE_TIME_MS),
    parameter [`ECT_TMR_W-1:0] BLOCK_CYC = `ECT_MS_TO_CYC(`ECT_BLOCK_ERASE_MS),
    parameter [`ECT_TMR_W-1:0] FULL_CYC  = `ECT_MS_TO_CYC(`ECT_FULL_ERASE_MS),
    parameter [`ECT_TMR_W-1:0] WAKE_CYC  = `ECT_US_TO_CYC(`ECT_WAKE_DELAY_US),
    parameter [`ECT_TMR_W-1:0] SLEEP_CYC = `ECT_US_TO_CYC(`ECT_SLEEP_DELAY_US)
)
(
    // clock and reset
    input  wire                    core_clk,
    input  wire                    sys_rst,
    // serial pins from the host
    input  wire                    select_n,
    input  wire                    sclk,
    input  wire                    sdi,
    input  wire                    pause_n,
    // serial output pin
    output reg                     sdo,
    output reg                     sdo_oe,
    // decoder side: received bytes
    output reg  [`ECT_BYTE_W-1:0]  rx_byte,
    output reg                     rx_valid,
    // decoder side: read data to shift out
    input  wire [`ECT_BYTE_W-1:0]  tx_byte,
    input  wire                    tx_load,
    // decoder side: action armed for the next select rise
    input  wire [`ECT_KIND_W-1:0]  arm_kind,
    // status
    output reg                     selected,
    output reg                     busy,
    output reg                     standby,
    output reg                     deep_pd,
    output reg                     cycle_done
);

    // state codes
    localparam [`ECT_ST_W-1:0] ST_IDLE  = `ECT_ST_IDLE;
    localparam [`ECT_ST_W-1:0] ST_PROG  = `ECT_ST_PROG;
    localparam [`ECT_ST_W-1:0] ST_SLEEP = `ECT_ST_SLEEP;
    localparam [`ECT_ST_W-1:0] ST_DEEP  = `ECT_ST_DEEP;
    localparam [`ECT_ST_W-1:0] ST_WAKE  = `ECT_ST_WAKE;

    // busy length for each programming kind; zero for kinds that do not program
    function [`ECT_TMR_W-1:0] prog_len;
        input [`ECT_KIND_W-1:0] kind;
        begin
            case (kind)
                `ECT_KIND_WRITE:       prog_len = WRITE_CYC;
                `ECT_KIND_PAGE_ERASE:  prog_len = WRITE_CYC;
                `ECT_KIND_BLOCK_ERASE: prog_len = BLOCK_CYC;
                `ECT_KIND_FULL_ERASE:  prog_len = FULL_CYC;
                default:               prog_len = `ECT_RST_TMR;
            endcase
        end
    endfunction

    // pin synchronisers: first stage read only by second stage
    reg [`ECT_PIN_N-1:0] pin_s1_reg;      // first stage
    reg [`ECT_PIN_N-1:0] pin_s2_reg;      // second stage, safe to use
    reg [`ECT_PIN_N-1:0] pin_d_reg;       // delayed copy for edge detection
    wire [`ECT_PIN_N-1:0] pin_raw;        // raw pin bundle

    assign pin_raw[`ECT_PIN_SEL]   = select_n;
    assign pin_raw[`ECT_PIN_SCLK]  = sclk;
    assign pin_raw[`ECT_PIN_SDI]   = sdi;
    assign pin_raw[`ECT_PIN_PAUSE] = pause_n;

    // idle pin levels: select high, clock low, data low, pause released
    genvar gi;
    generate
        for (gi = 0; gi < `ECT_PIN_N; gi = gi + 1)
        begin : g_sync
            localparam IDLE_HI = (gi == `ECT_PIN_SEL) || (gi == `ECT_PIN_PAUSE);
            always @(posedge core_clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    pin_s1_reg[gi] <= IDLE_HI ? 1'b1 : 1'b0;
                    pin_s2_reg[gi] <= IDLE_HI ? 1'b1 : 1'b0;
                    pin_d_reg[gi]  <= IDLE_HI ? 1'b1 : 1'b0;
                end
                else
                begin
                    pin_s1_reg[gi] <= pin_raw[gi];
                    pin_s2_reg[gi] <= pin_s1_reg[gi];
                    pin_d_reg[gi]  <= pin_s2_reg[gi];
                end
            end
        end
    endgenerate

    // clean levels and edges
    wire sel_low   = ~pin_s2_reg[`ECT_PIN_SEL];
    wire sel_rise  =  pin_s2_reg[`ECT_PIN_SEL] & ~pin_d_reg[`ECT_PIN_SEL];
    wire sclk_rise =  pin_s2_reg[`ECT_PIN_SCLK] & ~pin_d_reg[`ECT_PIN_SCLK];
    wire sclk_fall = ~pin_s2_reg[`ECT_PIN_SCLK] &  pin_d_reg[`ECT_PIN_SCLK];
    wire sdi_lvl   =  pin_s2_reg[`ECT_PIN_SDI];
    wire sclk_lvl  =  pin_s2_reg[`ECT_PIN_SCLK];
    wire pause_lvl = ~pin_s2_reg[`ECT_PIN_PAUSE];

    // internal state
    reg                     seen_low_reg;    // select seen low since reset
    reg                     paused_reg;      // pause in force for clocking
    reg [`ECT_ST_W-1:0]     state_reg;       // power and cycle state
    reg [`ECT_ST_W-1:0]     state_next;
    reg [`ECT_BYTE_W-1:0]   rx_sh_reg;       // incoming shift register
    reg [`ECT_BIT_W-1:0]    rx_cnt_reg;      // bits taken in this byte
    reg [`ECT_BYTE_W-1:0]   tx_sh_reg;       // outgoing shift register
    reg                     tx_act_reg;      // read data is being driven
    reg                     tmr_load;        // start the cycle timer
    reg [`ECT_TMR_W-1:0]    tmr_val;         // length for the timer
    wire                    tmr_done;        // timer finished

    // select gates everything; before the first low nothing is accepted
    wire active = sel_low & seen_low_reg;

    // shifting stops while paused
    wire shift_ok = active & ~paused_reg;

    // remember first low level on select after reset
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            seen_low_reg <= 1'b0;
        end
        else if (sel_low)
        begin
            seen_low_reg <= 1'b1;
        end
    end

    // pause only takes hold or lets go while the clock is low, as the host must arrange
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            paused_reg <= 1'b0;
        end
        else if (!active)
        begin
            paused_reg <= 1'b0;
        end
        else if (!sclk_lvl || sclk_fall)
        begin
            paused_reg <= pause_lvl;
        end
    end

    // receive path: sample on clock rise, first bit lands in the top bit
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rx_sh_reg  <= `ECT_RST_BYTE;
            rx_cnt_reg <= {`ECT_BIT_W{1'b0}};
            rx_byte    <= `ECT_RST_BYTE;
            rx_valid   <= 1'b0;
        end
        else if (!active)
        begin
            // a deselect abandons any partial byte
            rx_cnt_reg <= {`ECT_BIT_W{1'b0}};
            rx_valid   <= 1'b0;
        end
        else if (shift_ok && sclk_rise)
        begin
            rx_sh_reg  <= {rx_sh_reg[`ECT_BYTE_W-2:0], sdi_lvl};
            rx_cnt_reg <= rx_cnt_reg + {{(`ECT_BIT_W-1){1'b0}}, 1'b1};
            if (rx_cnt_reg == {`ECT_BIT_W{1'b1}})
            begin
                rx_byte  <= {rx_sh_reg[`ECT_BYTE_W-2:0], sdi_lvl};
                rx_valid <= 1'b1;
            end
            else
            begin
                rx_valid <= 1'b0;
            end
        end
        else
        begin
            rx_valid <= 1'b0;
        end
    end

    // transmit path: load a byte, then move one bit after each clock fall
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_sh_reg  <= `ECT_RST_BYTE;
            tx_act_reg <= 1'b0;
            sdo        <= 1'b0;
        end
        else if (!active)
        begin
            tx_act_reg <= 1'b0;
        end
        else if (tx_load)
        begin
            tx_sh_reg  <= tx_byte;
            tx_act_reg <= 1'b1;
        end
        else if (shift_ok && sclk_fall && tx_act_reg)
        begin
            sdo       <= tx_sh_reg[`ECT_BYTE_W-1];
            tx_sh_reg <= {tx_sh_reg[`ECT_BYTE_W-2:0], 1'b0};
        end
    end

    // output enable follows select and the synchronised pause level, not the clock
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sdo_oe <= 1'b0;
        end
        else
        begin
            sdo_oe <= active & tx_act_reg & ~pause_lvl;
        end
    end

    // next state; programming ignores select until the timer ends
    always @*
    begin
        state_next = state_reg;
        tmr_load   = 1'b0;
        tmr_val    = `ECT_RST_TMR;
        case (state_reg)
            ST_IDLE:
            begin
                if (sel_rise && seen_low_reg)
                begin
                    if (prog_len(arm_kind) != `ECT_RST_TMR)
                    begin
                        // launch on the rising select edge
                        state_next = ST_PROG;
                        tmr_load   = 1'b1;
                        tmr_val    = prog_len(arm_kind);
                    end
                    else if (arm_kind == `ECT_KIND_SLEEP)
                    begin
                        state_next = ST_SLEEP;
                        tmr_load   = 1'b1;
                        tmr_val    = SLEEP_CYC;
                    end
                end
            end
            ST_PROG:
            begin
                if (tmr_done)
                begin
                    state_next = ST_IDLE;
                end
            end
            ST_SLEEP:
            begin
                if (tmr_done)
                begin
                    state_next = ST_DEEP;
                end
            end
            ST_DEEP:
            begin
                // only a wake sequence leaves deep power-down
                if (sel_rise && arm_kind == `ECT_KIND_WAKE)
                begin
                    state_next = ST_WAKE;
                    tmr_load   = 1'b1;
                    tmr_val    = WAKE_CYC;
                end
            end
            ST_WAKE:
            begin
                if (tmr_done)
                begin
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // state register and registered status outputs
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg  <= ST_IDLE;
            selected   <= 1'b0;
            busy       <= 1'b0;
            standby    <= 1'b1;
            deep_pd    <= 1'b0;
            cycle_done <= 1'b0;
        end
        else
        begin
            state_reg  <= state_next;
            selected   <= active;
            busy       <= (state_next == ST_PROG);
            // standby waits for the cycle to end, then follows at once
            standby    <= ~active & (state_next == ST_IDLE);
            deep_pd    <= (state_next == ST_DEEP);
            cycle_done <= (state_reg == ST_PROG) & tmr_done;
        end
    end

    // one shared timer: the states that use it never overlap
    ect_cycle_timer u_timer
    (
        .core_clk (core_clk),
        .sys_rst  (sys_rst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .running  (),
        .done     (tmr_done)
    );

endmodule // ect_top

//--- test/ect_host_model.sv
`timescale 1ns/1ns

// host controller: drives select, serial clock, data and pause
module ect_host_model
(
    // clock
    input wire core_clk,
    // device output pin
    input wire sdo,
    input wire sdo_oe,
    // host pins
    output reg select_n,
    output reg sclk,
    output reg sdi,
    output reg pause_n
);
    reg  so_keep_reg;                        // last level seen on the line
    wire so_line = sdo_oe ? sdo : ~so_keep_reg; // released line toggles, never a stale bit

    initial
    begin
        select_n = 1'b1;
        sclk     = 1'b0; // clock stands low outside frames
        sdi      = 1'b0;
        pause_n  = 1'b1;
        so_keep_reg = 1'b0; // known start so a released line never reads unknown
    end

    // track the line so a released pin shows a changing pattern
    always @(posedge core_clk)
        so_keep_reg <= so_line;

    // select low opens a frame, high closes it and launches armed work
    task sel(input v);
        @(posedge core_clk) select_n <= v;
    endtask

    task pause(input v);
        @(posedge core_clk) pause_n <= v;
    endtask

    // n bits of tx, most significant first, 80 ns halves keep the rate low
    task xfer(input [7:0] tx, input integer n, output [7:0] rx);
        integer i;
        begin
            rx = 8'h00;
            for (i = 7; i > 7 - n; i = i - 1)
            begin
                repeat (4) @(posedge core_clk);
                sdi <= tx[i];
                repeat (4) @(posedge core_clk);
                sclk <= 1'b1;
                rx = {rx[6:0], so_line};
                repeat (8) @(posedge core_clk);
                sclk <= 1'b0;
                sdi  <= ~tx[i]; // wrong level after the fall exposes late sampling
            end
        end
    endtask
endmodule // ect_host_model

//--- test/ect_top_monitor.sv
`timescale 1ns/1ns
`include "ect_defs.vh"

// watches select, cycle timing and output enable at the top ports
module ect_top_monitor
#(
    parameter [`ECT_TMR_W-1:0] WRITE_CYC = 24'h00_003C,
    parameter [`ECT_TMR_W-1:0] BLOCK_CYC = 24'h00_0064,
    parameter [`ECT_TMR_W-1:0] FULL_CYC  = 24'h00_03E8,
    parameter [`ECT_TMR_W-1:0] WAKE_CYC  = 24'h00_0014,
    parameter [`ECT_TMR_W-1:0] SLEEP_CYC = 24'h00_0014
)
(
    // clock and reset
    input wire                   core_clk,
    input wire                   sys_rst,
    // host pins
    input wire                   select_n,
    input wire                   sclk,
    input wire                   sdi,
    input wire                   pause_n,
    input wire                   sdo,
    input wire                   sdo_oe,
    // decoder side
    input wire [`ECT_BYTE_W-1:0] rx_byte,
    input wire                   rx_valid,
    input wire [`ECT_BYTE_W-1:0] tx_byte,
    input wire                   tx_load,
    input wire [`ECT_KIND_W-1:0] arm_kind,
    // status
    input wire                   selected,
    input wire                   busy,
    input wire                   standby,
    input wire                   deep_pd,
    input wire                   cycle_done
);
    reg [23:0] busy_len_reg; // busy cycles so far
    reg [23:0] high_len_reg; // cycles the select pin has stayed high
    reg [3:0]  fall_age_reg; // cycles since the clock pin fell, saturating
    reg        sclk_d_reg;   // clock pin one cycle ago

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // counters that give the assertions their exact figures
    always @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            busy_len_reg <= 24'h00_0000;
            high_len_reg <= 24'h00_0000;
            fall_age_reg <= 4'h0;
            sclk_d_reg   <= 1'b0;
        end
        else
        begin
            busy_len_reg <= busy ? busy_len_reg + 24'h00_0001 : 24'h00_0000;
            high_len_reg <= select_n ? high_len_reg + 24'h00_0001 : 24'h00_0000;
            sclk_d_reg   <= sclk;
            // saturate so a long idle never wraps into a false recent fall
            if (sclk_d_reg && !sclk)
                fall_age_reg <= 4'h0;
            else if (fall_age_reg != 4'hF)
                fall_age_reg <= fall_age_reg + 4'h1;
        end
    end

    sequence s_start;
        $rose(busy);
    endsequence
    sequence s_hold;
        busy[*8];
    endsequence

    AST_SEL_LEVEL: assert property (select_n[*4] |-> !selected)
        else $error("selected while select pin high");
    AST_STBY_WAIT: assert property (busy |-> !standby)
        else $error("standby during a cycle");
    AST_STBY_AFTER: assert property ($fell(busy) && high_len_reg > 24'h00_0004 |-> standby)
        else $error("no standby after cycle while deselected");
    AST_OE_DESEL: assert property (!selected && $past(selected) == 1'b0 |-> !sdo_oe)
        else $error("output driven while deselected");
    AST_START_EDGE: assert property (s_start |-> high_len_reg >= 24'h00_0002 && high_len_reg <= 24'h00_0006)
        else $error("cycle start not tied to select rise");
    AST_BUSY_MIN: assert property (s_start |-> s_hold)
        else $error("cycle cut short");
    AST_CYCLE_LEN: assert property ($fell(busy) |-> cycle_done &&
        (busy_len_reg == WRITE_CYC || busy_len_reg == BLOCK_CYC || busy_len_reg == FULL_CYC))
        else $error("busy length wrong");
    AST_DONE_ONLY: assert property (cycle_done |-> $fell(busy))
        else $error("done pulse without cycle end");
    AST_SDO_FALL: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> fall_age_reg <= 4'h6)
        else $error("output changed away from clock fall");
    AST_PAUSE_OFF: assert property (!pause_n[*5] |-> !sdo_oe)
        else $error("output driven while paused");
    AST_DEEP_ENTRY: assert property ($rose(deep_pd) |->
        high_len_reg >= SLEEP_CYC && high_len_reg <= SLEEP_CYC + 24'h00_0006)
        else $error("sleep entry time wrong");
endmodule // ect_top_monitor

bind ect_top ect_top_monitor #(.WRITE_CYC(WRITE_CYC), .BLOCK_CYC(BLOCK_CYC), .FULL_CYC(FULL_CYC),
    .WAKE_CYC(WAKE_CYC), .SLEEP_CYC(SLEEP_CYC)) u_mon (.core_clk(core_clk), .sys_rst(sys_rst),
    .select_n(select_n), .sclk(sclk), .sdi(sdi), .pause_n(pause_n), .sdo(sdo), .sdo_oe(sdo_oe),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_byte(tx_byte), .tx_load(tx_load), .arm_kind(arm_kind),
    .selected(selected), .busy(busy), .standby(standby), .deep_pd(deep_pd), .cycle_done(cycle_done));

//--- test/serial_eeprom_select_and_cycle_timing_test.sv
`timescale 1ns/1ns
`include "ect_defs.vh"

module serial_eeprom_select_and_cycle_timing_test;
    localparam integer W_C = 60, B_C = 100, F_C = 1000, WK_C = 20, SL_C = 20; // shortened cycle counts
    reg        core_clk, sys_rst, tx_load;
    reg  [7:0] tx_byte;
    reg  [2:0] arm_kind;
    wire       select_n, sclk, sdi, pause_n, sdo, sdo_oe, rx_valid;
    wire       selected, busy, standby, deep_pd, cycle_done;
    wire [7:0] rx_byte;
    logic [7:0] exp_q[$];  // bytes the device should report
    integer    error_cnt = 0, checks = 0, run_len = 0, done_len = 0;
    integer    seed, kk, j, k;
    integer    lens[5] = '{0, W_C, W_C, B_C, F_C}; // busy length per armed kind
    reg  [7:0] b, r;

    always #5 core_clk = ~core_clk;

    ect_top #(.WRITE_CYC(W_C), .BLOCK_CYC(B_C), .FULL_CYC(F_C), .WAKE_CYC(WK_C), .SLEEP_CYC(SL_C)) u_dut
        (.core_clk(core_clk), .sys_rst(sys_rst), .select_n(select_n), .sclk(sclk), .sdi(sdi),
         .pause_n(pause_n), .sdo(sdo), .sdo_oe(sdo_oe), .rx_byte(rx_byte), .rx_valid(rx_valid),
         .tx_byte(tx_byte), .tx_load(tx_load), .arm_kind(arm_kind), .selected(selected), .busy(busy),
         .standby(standby), .deep_pd(deep_pd), .cycle_done(cycle_done));
    ect_host_model u_host (.core_clk(core_clk), .sdo(sdo), .sdo_oe(sdo_oe), .select_n(select_n),
        .sclk(sclk), .sdi(sdi), .pause_n(pause_n));

    task report_and_stop;
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task check(input [31:0] got, input [31:0] exp);
        checks = checks + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    function logic pick(input integer w);
        case (w)
            0: pick = busy;
            1: pick = deep_pd;
            2: pick = standby;
            3: pick = rx_valid;
            default: pick = sdo_oe;
        endcase
    endfunction

    // bounded wait for a status level; running out ends the run
    task wait_for(input integer w, input v, output integer n);
        n = 0;
        while (pick(w) !== v && n < 3000)
        begin
            @(posedge core_clk);
            n = n + 1;
        end
        if (n >= 3000)
        begin
            check(32'h0000_0000, 32'h0000_0001);
            report_and_stop;
        end
    endtask

    // reference: received bytes against the queue, busy length per cycle
    always @(posedge core_clk)
    begin
        if (rx_valid === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(32'h0000_0001, 32'h0000_0000);
            else
                check(rx_byte, exp_q.pop_front());
        end
        if (busy === 1'b1)
            run_len = run_len + 1;
        if (cycle_done === 1'b1)
        begin
            done_len = run_len;
            run_len = 0;
        end
    end

    initial
    begin
        seed = 32'he39e2320;
        core_clk = 1'b0;
        sys_rst = 1'b1;
        tx_load = 1'b0;
        tx_byte = $random(seed);
        arm_kind = 3'h0;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        check(standby, 1);
        // clocking with select never low must be ignored
        u_host.xfer($random(seed), 8, r);
        // every cycle kind, select toggled mid-cycle
        for (kk = 1; kk <= 4; kk = kk + 1)
        begin
            u_host.sel(1'b0);
            tx_byte <= $random(seed); // must stay unused without a load
            for (j = 0; j < 3; j = j + 1)
            begin
                b = $random(seed);
                exp_q.push_back(b);
                u_host.xfer(b, 8, r);
            end
            arm_kind <= kk[2:0];
            u_host.sel(1'b1);
            wait_for(0, 1'b1, k);
            check(k < 8, 1);
            arm_kind <= 3'h0;
            check(standby, 0);
            u_host.sel(1'b0);
            repeat (6) @(posedge core_clk);
            u_host.sel(1'b1);
            wait_for(0, 1'b0, k);
            repeat (2) @(posedge core_clk);
            check(done_len, lens[kk]);
            check(standby, 1);
        end
        // read back a byte, then pause and deselect the output
        u_host.sel(1'b0);
        b = $random(seed);
        exp_q.push_back(8'h03);
        exp_q.push_back(8'h00);
        fork
            u_host.xfer(8'h03, 8, r);
            begin
                wait_for(3, 1'b1, k);
                tx_byte <= b;
                tx_load <= 1'b1;
                @(posedge core_clk) tx_load <= 1'b0;
            end
        join
        u_host.xfer(8'h00, 8, r);
        check(r, b);
        u_host.pause(1'b0);
        wait_for(4, 1'b0, k);
        check(k < 6, 1);
        u_host.pause(1'b1);
        wait_for(4, 1'b1, k);
        check(k < 6, 1);
        u_host.sel(1'b1);
        wait_for(4, 1'b0, k);
        check(k < 6, 1);
        // partial byte dropped by deselect
        u_host.sel(1'b0);
        u_host.xfer($random(seed), 3, r);
        u_host.sel(1'b1);
        repeat (8) @(posedge core_clk);
        u_host.sel(1'b0);
        b = $random(seed);
        exp_q.push_back(b);
        u_host.xfer(b, 8, r);
        // sleep then wake
        arm_kind <= 3'h5;
        u_host.sel(1'b1);
        wait_for(1, 1'b1, k);
        check(k >= SL_C && k <= SL_C + 6, 1);
        check(standby, 0);
        arm_kind <= 3'h6;
        u_host.sel(1'b0);
        repeat (8) @(posedge core_clk);
        u_host.sel(1'b1);
        wait_for(1, 1'b0, k);
        check(k < 8, 1);
        wait_for(2, 1'b1, k);
        check(k <= WK_C + 6, 1);
        arm_kind <= 3'h0;
        check(exp_q.size(), 0);
        report_and_stop;
    end
endmodule // serial_eeprom_select_and_cycle_timing_test
